// File: hdl/aas_top.sv
// Summary of operation
// RL1 - Sequencer issues command and halts distributor
// RL2 - Steps advance only on gated clock pulses
// RL3 - Completion sends sequence done to clock
// RL4 - Set probe flop fires, then clears
// RL5 - Signed add: extended operand added, operand kept
// RL6 - Add: transfer, probe, final probe done
// RL7 - Transfer toggles lower stages where operand zero
// RL8 - Upper toggle flips every upper stage
// RL9 - Probes resolve borrows, completing the sum
// RL10 - Signed subtract leaves difference, complemented operand
// RL11 - Subtract sets deferred flag, complements operand
// RL12 - Deferred flag starts transfer, probe, final
// RL13 - Split add treats operand as positive
// RL14 - Split add always emits upper pulses
// RL15 - Split subtract flag, complement, lower-only chain
// RL16 - Split subtract never emits upper pulses
// RL17 - Split subtract leaves difference, complemented operand
// RL18 - Operand sign is its top bit
// RL19 - Extend flag withholds done, continues chain
`timescale 1ns/1ps
`default_nettype none

module aas_top (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      gated_clock_pulse,
    input  wire logic                      cmd_add,
    input  wire logic                      cmd_sub,
    input  wire logic                      cmd_split_add,
    input  wire logic                      cmd_split_sub,
    input  wire logic                      extend_seq,
    input  wire logic                      acc_load,
    input  wire logic [aas_pkg::ACC_W-1:0] acc_load_data,
    input  wire logic                      opd_load,
    input  wire logic [aas_pkg::OPD_W-1:0] opd_load_data,
    output logic                           sequence_done,
    output logic                           chain_extend,
    output logic                           complement_pulse,
    output logic                           xfer_pulse,
    output logic                           upper_toggle_pulse,
    output logic                           lower_carry_probe,
    output logic                           upper_carry_probe,
    output logic                           final_probe,
    output logic                           busy,
    output logic                           deferred_sum,
    output logic                           split_sub_flag,
    output logic                           fast_carry,
    output logic [aas_pkg::ACC_W-1:0]      acc_value,
    output logic [aas_pkg::OPD_W-1:0]      opd_value
);

    aas_pkg::aas_state_e state_r;
    aas_pkg::aas_state_e state_nxt;
    aas_pkg::aas_mode_e  mode_r;
    aas_pkg::aas_mode_e  mode_nxt;
    logic                defer_r;
    logic                defer_nxt;
    logic                ssub_r;
    logic                ssub_nxt;
    logic                upper_r;
    logic                upper_nxt;
    logic                any_cmd;
    logic                start_sub;
    logic                start_ssub;
    logic                upper_sel;
    logic                opd_pos;
    logic                idle;
    logic                load_ok;

    aas_dp_if dpi ();

    aas_datapath u_dp (
        .clk   (clk),
        .rst_n (rst_n),
        .dpi   (dpi)
    );

    // ==========================================================
    // Command decode
    assign idle       = (state_r == aas_pkg::AAS_IDLE);
    assign any_cmd    = cmd_add | cmd_sub | cmd_split_add | cmd_split_sub;
    // A load never lands while a sequence owns the registers
    assign load_ok    = idle & ~any_cmd;

    // Complement only for the command that wins the priority order
    always_comb
    begin
        start_sub  = 1'b0;
        start_ssub = 1'b0;
        if (idle & ~cmd_add)
        begin
            if (cmd_sub)
            begin
                start_sub = 1'b1; // RL11
            end
            else if (~cmd_split_add & cmd_split_sub)
            begin
                start_ssub = 1'b1; // RL15
            end
        end
    end

    // Positive when the top operand bit is zero
    assign opd_pos = ~dpi.opd[aas_pkg::OPD_SIGN_BIT]; // RL18

    // ==========================================================
    // Upper half participation per sequence kind
    // Read at the transfer, after any complement, so a subtract tests
    // the sign of the negated subtrahend
    always_comb
    begin
        case (mode_r)
            aas_pkg::AAS_M_ADD:
            begin
                upper_sel = opd_pos; // RL6
            end
            aas_pkg::AAS_M_SUB:
            begin
                upper_sel = opd_pos; // RL12
            end
            aas_pkg::AAS_M_SADD:
            begin
                upper_sel = 1'b1; // RL14
            end
            aas_pkg::AAS_M_SSUB:
            begin
                upper_sel = 1'b0; // RL16
            end
            default:
            begin
                upper_sel = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Sequencer next state
    always_comb
    begin
        state_nxt = state_r;
        mode_nxt  = mode_r;
        defer_nxt = defer_r;
        ssub_nxt  = ssub_r;
        upper_nxt = upper_r;
        case (state_r)
            aas_pkg::AAS_IDLE:
            begin
                // Only an idle sequencer listens; later commands are dropped
                // Command from the instruction sequencer arms step one
                if (any_cmd)
                begin
                    state_nxt = aas_pkg::AAS_XFER; // RL1
                    upper_nxt = 1'b0;
                    if (cmd_add)
                    begin
                        mode_nxt = aas_pkg::AAS_M_ADD; // RL5
                    end
                    else if (cmd_sub)
                    begin
                        mode_nxt  = aas_pkg::AAS_M_SUB;
                        defer_nxt = 1'b1; // RL11
                    end
                    else if (cmd_split_add)
                    begin
                        mode_nxt = aas_pkg::AAS_M_SADD; // RL13
                    end
                    else
                    begin
                        mode_nxt = aas_pkg::AAS_M_SSUB;
                        ssub_nxt = 1'b1; // RL15
                    end
                end
            end
            aas_pkg::AAS_XFER:
            begin
                if (gated_clock_pulse) // RL2
                begin
                    // Both launch flags are spent once the transfer fires
                    state_nxt = aas_pkg::AAS_PROBE; // RL4
                    defer_nxt = 1'b0; // RL12
                    ssub_nxt  = 1'b0; // RL15
                    upper_nxt = upper_sel;
                end
            end
            aas_pkg::AAS_PROBE:
            begin
                if (gated_clock_pulse) // RL2
                begin
                    // The whole borrow resolves here, upper strobe or not
                    state_nxt = aas_pkg::AAS_FINAL; // RL4
                end
            end
            aas_pkg::AAS_FINAL:
            begin
                if (gated_clock_pulse) // RL2
                begin
                    // An extended chain hands over through chain_extend
                    state_nxt = aas_pkg::AAS_IDLE; // RL4
                    upper_nxt = 1'b0;
                end
            end
            default:
            begin
                state_nxt = aas_pkg::AAS_IDLE;
                defer_nxt = 1'b0;
                ssub_nxt  = 1'b0;
                upper_nxt = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Sequencer registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r <= aas_pkg::AAS_IDLE;
            mode_r  <= aas_pkg::AAS_M_ADD;
            defer_r <= 1'b0;
            ssub_r  <= 1'b0;
            upper_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            mode_r  <= mode_nxt;
            defer_r <= defer_nxt;
            ssub_r  <= ssub_nxt;
            upper_r <= upper_nxt;
        end
    end

    // ==========================================================
    // Probe pulses
    // The armed step fires on the next gated pulse, and the same
    // pulse moves the state on, which disarms it
    always_comb
    begin
        xfer_pulse        = 1'b0;
        lower_carry_probe = 1'b0;
        final_probe       = 1'b0;
        case (state_r)
            aas_pkg::AAS_XFER:
            begin
                xfer_pulse = gated_clock_pulse; // RL4
            end
            aas_pkg::AAS_PROBE:
            begin
                lower_carry_probe = gated_clock_pulse; // RL4
            end
            aas_pkg::AAS_FINAL:
            begin
                final_probe = gated_clock_pulse; // RL4
            end
            default:
            begin
                xfer_pulse        = 1'b0;
                lower_carry_probe = 1'b0;
                final_probe       = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Pulses that ride on the command and the probe steps
    always_comb
    begin
        complement_pulse   = start_sub | start_ssub; // RL11
        upper_toggle_pulse = xfer_pulse & upper_sel; // RL8
        upper_carry_probe  = lower_carry_probe & upper_r; // RL9
        // Done is withheld while the chain is to be extended
        sequence_done      = final_probe & ~extend_seq; // RL3
        chain_extend       = final_probe & extend_seq; // RL19
    end

    // ==========================================================
    // Datapath steering
    // Steps reach the datapath as one-cycle strobes
    assign dpi.acc_load      = acc_load & load_ok;
    assign dpi.acc_load_data = acc_load_data;
    assign dpi.opd_load      = opd_load & load_ok;
    assign dpi.opd_load_data = opd_load_data;
    assign dpi.complement    = complement_pulse; // RL10
    assign dpi.xfer          = xfer_pulse; // RL7
    assign dpi.upper_toggle  = upper_toggle_pulse; // RL8
    assign dpi.lower_probe   = lower_carry_probe; // RL9

    // ==========================================================
    // Status
    // Busy is the halt request the clock system sees
    assign busy           = ~idle;
    assign deferred_sum   = defer_r;
    assign split_sub_flag = ssub_r;
    assign fast_carry     = dpi.fast_carry;
    assign acc_value      = dpi.acc; // RL17
    assign opd_value      = dpi.opd;

endmodule

`default_nettype wire

// File: hdl/aas_pkg.sv
package aas_pkg;

    // ==========================================================
    // Widths
    localparam int OPD_W  = 36;
    localparam int ACC_W  = 72;
    localparam int HALF_W = 36;

    // ==========================================================
    // Reset values and fixed patterns
    localparam logic [ACC_W-1:0] ACC_RST  = 72'h00_0000_0000_0000_0000;
    localparam logic [OPD_W-1:0] OPD_RST  = 36'h0_0000_0000;
    localparam logic [HALF_W-1:0] HALF_ONES = 36'hF_FFFF_FFFF;
    localparam logic [HALF_W-1:0] HALF_ZERO = 36'h0_0000_0000;
    localparam logic [ACC_W-1:0] ACC_ONE  = 72'h00_0000_0000_0000_0001;

    // ==========================================================
    // Field positions
    localparam int OPD_SIGN_BIT = 35;

    // ==========================================================
    // Sequencer states
    typedef enum logic [4:0] {
        AAS_IDLE  = 5'b0_0001,
        AAS_XFER  = 5'b0_0010,
        AAS_PROBE = 5'b0_0100,
        AAS_FINAL = 5'b0_1000,
        AAS_SPARE = 5'b1_0000
    } aas_state_e;

    // Sequence kinds
    typedef enum logic [3:0] {
        AAS_M_ADD    = 4'b0001,
        AAS_M_SUB    = 4'b0010,
        AAS_M_SADD   = 4'b0100,
        AAS_M_SSUB   = 4'b1000
    } aas_mode_e;

endpackage

// File: hdl/aas_dp_if.sv
`timescale 1ns/1ps
`default_nettype none

interface aas_dp_if;
    logic                        acc_load;
    logic [aas_pkg::ACC_W-1:0]   acc_load_data;
    logic                        opd_load;
    logic [aas_pkg::OPD_W-1:0]   opd_load_data;
    logic                        complement;
    logic                        xfer;
    logic                        upper_toggle;
    logic                        lower_probe;
    logic [aas_pkg::ACC_W-1:0]   acc;
    logic [aas_pkg::OPD_W-1:0]   opd;
    logic                        fast_carry;

    modport ctl (
        output acc_load,
        output acc_load_data,
        output opd_load,
        output opd_load_data,
        output complement,
        output xfer,
        output upper_toggle,
        output lower_probe,
        input  acc,
        input  opd,
        input  fast_carry
    );

    modport dp (
        input  acc_load,
        input  acc_load_data,
        input  opd_load,
        input  opd_load_data,
        input  complement,
        input  xfer,
        input  upper_toggle,
        input  lower_probe,
        output acc,
        output opd,
        output fast_carry
    );
endinterface

`default_nettype wire

// File: hdl/aas_datapath.sv
`timescale 1ns/1ps
`default_nettype none

module aas_datapath (
    input  wire logic clk,
    input  wire logic rst_n,
    aas_dp_if.dp      dpi
);

    logic [aas_pkg::ACC_W-1:0]  acc_r;
    logic [aas_pkg::ACC_W-1:0]  acc_nxt;
    logic [aas_pkg::OPD_W-1:0]  opd_r;
    logic [aas_pkg::OPD_W-1:0]  opd_nxt;
    logic [aas_pkg::ACC_W-1:0]  orig_r;
    logic [aas_pkg::ACC_W-1:0]  orig_nxt;
    logic [aas_pkg::ACC_W-1:0]  subt_r;
    logic [aas_pkg::ACC_W-1:0]  subt_nxt;
    logic                       fcar_r;
    logic                       fcar_nxt;
    logic [aas_pkg::ACC_W:0]    diff;
    logic [aas_pkg::HALF_W-1:0] up_term;

    // ==========================================================
    // Next values
    always_comb
    begin
        acc_nxt  = acc_r;
        opd_nxt  = opd_r;
        orig_nxt = orig_r;
        subt_nxt = subt_r;
        fcar_nxt = fcar_r;
        up_term  = dpi.upper_toggle ? aas_pkg::HALF_ONES
                                    : aas_pkg::HALF_ZERO;
        diff     = {1'b0, orig_r} - {1'b0, subt_r};
        if (dpi.acc_load)
        begin
            acc_nxt = dpi.acc_load_data;
        end
        if (dpi.opd_load)
        begin
            opd_nxt = dpi.opd_load_data;
        end
        if (dpi.complement)
        begin
            opd_nxt = ~opd_r; // RL11
        end
        if (dpi.xfer)
        begin
            // Partial sums: lower toggled where operand is zero
            orig_nxt = acc_r;
            subt_nxt = {up_term, ~opd_r};
            acc_nxt  = {acc_r[71:36] ^ up_term,
                        acc_r[35:0] ^ ~opd_r}; // RL7
        end
        if (dpi.lower_probe)
        begin
            // Borrow resolution with end-around borrow
            fcar_nxt = diff[aas_pkg::ACC_W]; // RL9
            acc_nxt  = diff[aas_pkg::ACC_W] ?
                       diff[aas_pkg::ACC_W-1:0] - aas_pkg::ACC_ONE :
                       diff[aas_pkg::ACC_W-1:0]; // RL9
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            acc_r  <= aas_pkg::ACC_RST;
            opd_r  <= aas_pkg::OPD_RST;
            orig_r <= aas_pkg::ACC_RST;
            subt_r <= aas_pkg::ACC_RST;
            fcar_r <= 1'b0;
        end
        else
        begin
            acc_r  <= acc_nxt;
            opd_r  <= opd_nxt;
            orig_r <= orig_nxt;
            subt_r <= subt_nxt;
            fcar_r <= fcar_nxt;
        end
    end

    assign dpi.acc        = acc_r;
    assign dpi.opd        = opd_r;
    assign dpi.fast_carry = fcar_r;

endmodule

`default_nettype wire

// File: bench/aas_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Checker on the sequencer ports
module aas_asserts (
    input wire logic                      clk,
    input wire logic                      rst_n,
    input wire logic                      gated_clock_pulse,
    input wire logic                      cmd_add,
    input wire logic                      cmd_sub,
    input wire logic                      extend_seq,
    input wire logic                      sequence_done,
    input wire logic                      chain_extend,
    input wire logic                      complement_pulse,
    input wire logic                      xfer_pulse,
    input wire logic                      upper_toggle_pulse,
    input wire logic                      lower_carry_probe,
    input wire logic                      upper_carry_probe,
    input wire logic                      final_probe,
    input wire logic                      busy,
    input wire logic                      deferred_sum,
    input wire logic                      split_sub_flag,
    input wire logic [aas_pkg::ACC_W-1:0] acc_value,
    input wire logic [aas_pkg::OPD_W-1:0] opd_value
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_steps_gated: assert property (
        (xfer_pulse || lower_carry_probe || final_probe) |-> gated_clock_pulse)
        else $error("step without gated pulse");
    chk_done_final: assert property (
        sequence_done |-> final_probe && !extend_seq && !chain_extend)
        else $error("done without final probe");
    chk_extend_hold: assert property (
        final_probe && extend_seq |-> chain_extend && !sequence_done)
        else $error("done not withheld");
    chk_xfer_then: assert property (
        xfer_pulse ##1 gated_clock_pulse |-> lower_carry_probe)
        else $error("lower probe not next");
    chk_probe_then: assert property (
        lower_carry_probe ##1 gated_clock_pulse |-> final_probe)
        else $error("final probe not next");
    chk_final_idle: assert property (
        final_probe |=> !busy)
        else $error("busy after final probe");
    chk_upper_pair: assert property (
        (upper_toggle_pulse |-> xfer_pulse) and
        (upper_carry_probe |-> lower_carry_probe))
        else $error("upper pulse out of step");
    chk_split_noup: assert property (
        split_sub_flag && xfer_pulse |-> !upper_toggle_pulse)
        else $error("upper toggle in split subtract");
    chk_sign_sel: assert property (
        deferred_sum && xfer_pulse |-> upper_toggle_pulse == !opd_value[35])
        else $error("upper choice wrong");
    chk_opd_cmpl: assert property (
        complement_pulse |=> opd_value == ~$past(opd_value))
        else $error("operand not complemented");
    chk_flag_set: assert property (
        !busy && cmd_sub && !cmd_add |=> deferred_sum && busy)
        else $error("deferred flag not set");
    chk_xfer_acc: assert property (
        xfer_pulse |=> acc_value[35:0] ==
        ($past(acc_value[35:0]) ^ ~$past(opd_value)))
        else $error("partial sum wrong");

    cover property (xfer_pulse && upper_toggle_pulse);
    cover property (split_sub_flag && xfer_pulse);
    cover property (chain_extend);
    cover property (sequence_done);
endmodule

bind aas_top aas_asserts u_chk (.clk, .rst_n, .gated_clock_pulse, .cmd_add,
    .cmd_sub, .extend_seq, .sequence_done, .chain_extend, .complement_pulse,
    .xfer_pulse, .upper_toggle_pulse, .lower_carry_probe, .upper_carry_probe,
    .final_probe, .busy, .deferred_sum, .split_sub_flag, .acc_value,
    .opd_value);
`default_nettype wire

// File: bench/aas_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Instruction sequencer and clock system
module aas_seq_model (
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic           go,
    input  var aas_pkg::aas_mode_e mode,
    input  wire logic [3:0]     gap,
    input  wire logic           sequence_done,
    input  wire logic           chain_extend,
    output logic                cmd_add,
    output logic                cmd_sub,
    output logic                cmd_split_add,
    output logic                cmd_split_sub,
    output logic                gated_clock_pulse,
    output logic                run,
    output logic                mpd_adv
);
    logic [3:0] cnt;
    logic       st;
    logic       fin;

    assign st = go && !run && rst_n;
    assign fin = sequence_done || chain_extend;
    // Distributor stands still while a sequence runs
    assign mpd_adv = !run;
    always @(posedge clk)
    begin
        cmd_add <= st && mode == aas_pkg::AAS_M_ADD;
        cmd_sub <= st && mode == aas_pkg::AAS_M_SUB;
        cmd_split_add <= st && mode == aas_pkg::AAS_M_SADD;
        cmd_split_sub <= st && mode == aas_pkg::AAS_M_SSUB;
        run <= rst_n && (st || (run && !fin));
        gated_clock_pulse <= rst_n && run && !fin && cnt == gap;
        cnt <= (!run || cnt == gap) ? 4'h0 : cnt + 4'h1;
    end
endmodule
`default_nettype wire

// File: bench/aas_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
// ==========================================
// Testbench
module aas_top_tb;
    logic                      clk;
    logic                      rst_n;
    logic                      go;
    logic                      ext;
    logic [3:0]                gap;
    aas_pkg::aas_mode_e        mode;
    logic                      acc_load;
    logic                      opd_load;
    logic [aas_pkg::ACC_W-1:0] acc_load_data;
    logic [aas_pkg::OPD_W-1:0] opd_load_data;
    logic                      gp;
    logic                      ca;
    logic                      cs;
    logic                      csa;
    logic                      css;
    logic                      run;
    logic                      sequence_done;
    logic                      chain_extend;
    logic                      complement_pulse;
    logic                      xfer_pulse;
    logic                      upper_toggle_pulse;
    logic                      lower_carry_probe;
    logic                      upper_carry_probe;
    logic                      final_probe;
    logic                      busy;
    logic                      fast_carry;
    logic                      clr_hit;
    logic [aas_pkg::ACC_W-1:0] acc_value;
    logic [aas_pkg::OPD_W-1:0] opd_value;
    logic [7:0]                pv;
    logic [7:0]                hit;
    logic [7:0]                dbl;
    int                        n_errors = 0;
    int                        cmp_count = 0;

    aas_seq_model u_seq (.clk, .rst_n, .go, .mode, .gap, .sequence_done,
        .chain_extend, .cmd_add(ca), .cmd_sub(cs), .cmd_split_add(csa),
        .cmd_split_sub(css), .gated_clock_pulse(gp), .run, .mpd_adv());
    aas_top DUT (.clk, .rst_n, .gated_clock_pulse(gp), .cmd_add(ca),
        .cmd_sub(cs), .cmd_split_add(csa), .cmd_split_sub(css),
        .extend_seq(ext), .acc_load, .acc_load_data, .opd_load,
        .opd_load_data, .sequence_done, .chain_extend, .complement_pulse,
        .xfer_pulse, .upper_toggle_pulse, .lower_carry_probe,
        .upper_carry_probe, .final_probe, .busy, .deferred_sum(),
        .split_sub_flag(), .fast_carry, .acc_value, .opd_value);

    assign pv = {complement_pulse, chain_extend, sequence_done, final_probe,
        upper_carry_probe, lower_carry_probe, upper_toggle_pulse, xfer_pulse};
    always #25 clk = ~clk;
    always @(posedge clk)
    begin
        dbl <= clr_hit ? 8'h00 : dbl | (hit & pv);
        hit <= clr_hit ? 8'h00 : hit | pv;
    end

    // Ones' complement sum with end-around carry; the borrow flag is
    // set when there is no carry and the sum is not all ones
    function automatic logic [72:0] exp_res(input logic [71:0] a,
        input logic [35:0] xe, input logic ups);
        logic [72:0] s;
        logic [35:0] hi;
        hi = ups ? 36'h0_0000_0000 : aas_pkg::HALF_ONES;
        s = {1'b0, a} + {1'b0, hi, xe};
        return {!s[72] && (s[71:0] != {72{1'b1}}),
            s[71:0] + {71'h0, s[72]}};
    endfunction

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic run_seq(input aas_pkg::aas_mode_e m,
        input logic [71:0] a, input logic [35:0] x, input logic [3:0] g,
        input logic e);
        logic        sb;
        logic        ups;
        logic [35:0] xe;
        logic [15:0] pe;
        logic [72:0] re;
        sb = m == aas_pkg::AAS_M_SUB || m == aas_pkg::AAS_M_SSUB;
        xe = sb ? ~x : x;
        ups = m == aas_pkg::AAS_M_SADD
            || (m != aas_pkg::AAS_M_SSUB && !xe[35]);
        pe = {8'h00, sb, e, !e, 1'b1, ups, 1'b1, ups, 1'b1};
        re = exp_res(a, xe, ups);
        acc_load = 1'b1;
        acc_load_data = a;
        opd_load = 1'b1;
        opd_load_data = x;
        clr_hit = 1'b1;
        @(negedge clk);
        acc_load = 1'b0;
        opd_load = 1'b0;
        clr_hit = 1'b0;
        mode = m;
        gap = g;
        ext = e;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        for (int i = 0; i < 100 && run; i++)
            @(negedge clk);
        if (run)
        begin
            n_errors++;
            wrap_up();
        end
        `CHK({dbl, hit}, pe)
        `CHK({fast_carry, acc_value}, re)
        `CHK(opd_value, xe)
        `CHK(busy, 1'b0)
    endtask

    task automatic t_add();
        run_seq(aas_pkg::AAS_M_ADD, 72'h00_0000_0000_0000_0061,
            36'h0_0000_0005, 4'h0, 1'b0);
        run_seq(aas_pkg::AAS_M_ADD, 72'h12_3456_789A_BCDE_F012,
            36'hF_FFFF_FFF9, 4'h2, 1'b0);
        $display("test add done");
    endtask

    task automatic t_sub();
        run_seq(aas_pkg::AAS_M_SUB, 72'h00_0000_0000_0000_0021,
            36'hF_FFFF_FFFE, 4'h0, 1'b0);
        run_seq(aas_pkg::AAS_M_SUB, 72'hFF_FFFF_FFFF_0000_0001,
            36'h0_0000_1234, 4'h1, 1'b0);
        $display("test sub done");
    endtask

    task automatic t_split();
        run_seq(aas_pkg::AAS_M_SADD, 72'hFF_FFFF_FFFF_FFFF_FFB6,
            36'hF_0000_000D, 4'h1, 1'b0);
        run_seq(aas_pkg::AAS_M_SSUB, 72'hFF_FFFF_FFFF_FFFF_FFB6,
            36'h8_0000_000D, 4'h3, 1'b0);
        $display("test split done");
    endtask

    task automatic t_reset();
        mode = aas_pkg::AAS_M_SUB;
        gap = 4'h3;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        repeat (3) @(negedge clk);
        `CHK(busy, 1'b1)
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        `CHK({busy, fast_carry, acc_value, opd_value}, 110'h0)
        $display("test reset done");
    endtask

    task automatic t_ext();
        run_seq(aas_pkg::AAS_M_ADD, 72'h00_0000_0000_0000_0000,
            36'h0_0000_0000, 4'h0, 1'b1);
        $display("test extend done");
    endtask

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        go = 1'b0;
        ext = 1'b0;
        gap = 4'h0;
        mode = aas_pkg::AAS_M_ADD;
        acc_load = 1'b0;
        opd_load = 1'b0;
        clr_hit = 1'b0;
        acc_load_data = aas_pkg::ACC_RST;
        opd_load_data = aas_pkg::OPD_RST;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        `CHK({busy, acc_value, opd_value}, 109'h0)
        t_add();
        t_sub();
        t_split();
        t_reset();
        t_ext();
        wrap_up();
    end
endmodule
`default_nettype wire
